// >>> fan_ctrl_pkg.sv
// Purpose: shared constants and types for the fan speed controller
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes: times kept in their own unit, cycle counts derived from them
package fan_ctrl_pkg;

    // clock and time base
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1000;                 // 1 ms time base
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int PWM_FREQ_KHZ = 25;
    localparam int PWM_PERIOD_CYC = CLK_MHZ * 1000 / PWM_FREQ_KHZ;
    localparam int PWM_STEP_CYC = PWM_PERIOD_CYC / 100;  // cycles per percent

    // forced full speed timing, in seconds and in 1 ms ticks
    localparam int STARTUP_S = 5;
    localparam int STARTUP_TICKS = STARTUP_S * 1000;
    localparam int BACKUP_LONG_S = 30;
    localparam int BACKUP_LONG_TICKS = BACKUP_LONG_S * 1000;
    localparam int HOLD_S = 60;
    localparam int HOLD_TICKS = HOLD_S * 1000 + 1;  // +1 covers a partial tick
    localparam int FAN_SPEED_PULSE_IN_WIN_MS = 1000;

    // duty limits in percent
    localparam logic [7:0] DUTY_FULL = 8'h64;      // 100 percent
    localparam logic [7:0] DUTY_FLOOR_MIN = 8'h1e; // 30 percent

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CURVE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_FAN_SPEED_PULSE_IN = 8'h14;
    localparam logic [7:0] OFS_FAN_SPEED_PULSE_IN_LIM = 8'h18;

    // reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_001e;
    localparam logic [31:0] RST_CURVE = 32'h0000_0219;  // gain 2, from 25 C
    localparam logic [31:0] RST_FAN_SPEED_PULSE_IN_LIM = 32'h03e8_0014;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;

    // interrupt bit positions
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_RESUME = 1;
    localparam int IRQ_FORCED = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [22:0] rsvd;
        logic two_fan;
        logic [7:0] floor_pct;
    } ctrl_reg_t;

    typedef struct packed {
        logic [15:0] rsvd;
        logic [7:0] gain;      // percent per degree above t_low
        logic [7:0] t_low;     // degrees C where the ramp starts
    } curve_reg_t;

    typedef struct packed {
        logic [15:0] max_cnt;  // pulses per window, above is implausible
        logic [15:0] min_cnt;  // pulses per window, below is stalled
    } fan_speed_pulse_in_lim_t;

    typedef enum logic [1:0] {
        MODE_STARTUP = 2'b00,
        MODE_FORCED = 2'b01,
        MODE_REGULATE = 2'b10,
        MODE_FAULT = 2'b11
    } fan_mode_t;

endpackage

// >>> fan_speed_ctrl.sv
// Purpose: fan pwm generator with temperature law and fan_speed_pulse_in supervision
// Assumes: all inputs synchronous to clk_in, temp_in in whole degrees C
// Notes: fault is sticky until reset; registers over AXI4-Lite
//
// Functional notes
// R1 - pwm duty never goes below 30 percent
// R2 - floor is configurable upward only; values under 30 are raised to 30
// R3 - normal duty follows a linear curve of intake air temperature
// R4 - duty depends on temperature and forcing only, never on output current
// R5 - after power up the fan runs full speed, then regulation takes over
// R6 - fan_speed_pulse_in monitoring shuts down on stalled, blocked or implausible speed
// R7 - any fan fault turns on the red fail indicator
// R8 - with two fans, either fan failing is a fan fault
// R9 - backup or battery test forces full speed
// R10 - full speed held 1 minute after test or backup over 30 s
// R11 - leaving forced speed resumes clamped curve duty without stopping
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fan_speed_ctrl
    import fan_ctrl_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC,
    parameter int STARTUP_TICKS_P = STARTUP_TICKS,
    parameter int BACKUP_LONG_TICKS_P = BACKUP_LONG_TICKS,
    parameter int HOLD_TICKS_P = HOLD_TICKS
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] temp_in,
    input wire logic backup_in,
    input wire logic battery_test_in,
    input wire logic [1:0] fan_speed_pulse_in,
    output logic fan_pwm_out,
    output logic fail_led_out,
    output logic shutdown_out,
    output logic irq_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);

    // register state
    ctrl_reg_t ctrl_ff;
    curve_reg_t curve_ff;
    fan_speed_pulse_in_lim_t lim_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    // axi state
    logic aw_have_ff, w_have_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    // control state
    fan_mode_t mode_ff;
    logic [31:0] tick_cnt_ff;
    logic [31:0] start_cnt_ff, bk_cnt_ff, hold_cnt_ff;
    logic backup_d_ff, test_d_ff, forced_d_ff;
    logic [7:0] duty_ff;
    logic [31:0] pre_cnt_ff;
    logic [6:0] pwm_cnt_ff;
    logic pwm_ff, fail_ff, irq_ff;
    logic [15:0] win_cnt_ff;
    logic [1:0] fan_fault;
    logic [15:0] fan_speed_pulse_in_last [2];

    // time base and axi handshakes
    wire tick = (tick_cnt_ff == 32'(TICK_CYC_P - 1));
    wire aw_fire = s_axi_awvalid_in & awready_ff;
    wire w_fire = s_axi_wvalid_in & wready_ff;
    wire do_wr = aw_have_ff & w_have_ff & ~bvalid_ff;
    wire ar_fire = s_axi_arvalid_in & arready_ff;
    wire nxt_aw_have = aw_fire | (aw_have_ff & ~do_wr);
    wire nxt_w_have = w_fire | (w_have_ff & ~do_wr);
    wire nxt_rvalid = ar_fire | (rvalid_ff & ~s_axi_rready_in);

    // byte lane mask from write strobes
    logic [31:0] wmask;
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_lane
            assign wmask[gb*8 +: 8] = {8{wstrb_ff[gb]}};
        end
    endgenerate

    // write decode
    wire wr_ctrl = do_wr & (awaddr_ff == OFS_CTRL);
    wire wr_curve = do_wr & (awaddr_ff == OFS_CURVE);
    wire wr_istat = do_wr & (awaddr_ff == OFS_IRQ_STAT);
    wire wr_imask = do_wr & (awaddr_ff == OFS_IRQ_MASK);
    wire wr_lim = do_wr & (awaddr_ff == OFS_FAN_SPEED_PULSE_IN_LIM);
    wire wr_ro = do_wr & ((awaddr_ff == OFS_STATUS) |
        (awaddr_ff == OFS_FAN_SPEED_PULSE_IN));
    wire wr_hit = wr_ctrl | wr_curve | wr_istat | wr_imask | wr_lim | wr_ro;
    wire [31:0] wmerge_ctrl = (ctrl_ff & ~wmask) | (wdata_ff & wmask);
    wire [31:0] wmerge_curve = (curve_ff & ~wmask) | (wdata_ff & wmask);
    wire [31:0] wmerge_lim = (lim_ff & ~wmask) | (wdata_ff & wmask);
    wire [2:0] w1c = wr_istat ? (wdata_ff[2:0] & wmask[2:0]) : 3'h0;

    // forcing conditions and effective floor
    wire startup = (mode_ff == MODE_STARTUP);
    wire hold = (hold_cnt_ff != 32'h0000_0000);
    // hold starts in the cycle the test or long backup ends, no dip
    wire hold_start = (test_d_ff & ~battery_test_in) | (backup_d_ff &
        ~backup_in & (bk_cnt_ff >= 32'(BACKUP_LONG_TICKS_P))); // R10
    wire forced = startup | backup_in | battery_test_in | hold |
        hold_start; // R5 R9 R10
    wire [7:0] floor_eff = (ctrl_ff.floor_pct < DUTY_FLOOR_MIN) ?
        DUTY_FLOOR_MIN : ctrl_ff.floor_pct; // R2
    wire [7:0] floor_cap = (floor_eff > DUTY_FULL) ? DUTY_FULL : floor_eff;

    // temperature curve, only temperature, curve settings and floor feed it
    wire [7:0] t_over = (temp_in > curve_ff.t_low) ?
        (temp_in - curve_ff.t_low) : 8'h00; // R3 R4
    wire [16:0] ramp = {1'b0, 16'(t_over) * 16'(curve_ff.gain)} +
        {9'h000, floor_cap}; // product kept at full width
    wire [7:0] curve_duty = (ramp > {9'h000, DUTY_FULL}) ?
        DUTY_FULL : ramp[7:0]; // R1 R3
    wire [7:0] target_duty = (forced | fail_ff) ? DUTY_FULL : curve_duty; // R11

    // fan_speed_pulse_in pulse counting and window checks, one per fan
    wire win_end = tick & (win_cnt_ff == 16'(FAN_SPEED_PULSE_IN_WIN_MS - 1));
    wire mon_en = (mode_ff != MODE_STARTUP);
    genvar gf;
    generate
        for (gf = 0; gf < 2; gf++)
        begin : g_fan
            logic pulse_d_ff;
            logic [15:0] pcnt_ff;
            logic [15:0] last_ff;
            wire rise = fan_speed_pulse_in[gf] & ~pulse_d_ff;
            wire used = (gf == 0) | ctrl_ff.two_fan; // R8
            wire slow = pcnt_ff < lim_ff.min_cnt;  // stalled or blocked
            wire odd = pcnt_ff > lim_ff.max_cnt;   // implausible reading
            assign fan_fault[gf] = win_end & mon_en & used & (slow | odd); // R6
            assign fan_speed_pulse_in_last[gf] = last_ff;
            always_ff @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    pulse_d_ff <= 1'b0;
                    pcnt_ff <= 16'h0000;
                    last_ff <= 16'h0000;
                end
                else
                begin
                    pulse_d_ff <= fan_speed_pulse_in[gf];
                    if (win_end)
                    begin
                        last_ff <= pcnt_ff;
                        pcnt_ff <= {15'h0000, rise};
                    end
                    else if (rise && pcnt_ff != 16'hffff)
                        pcnt_ff <= pcnt_ff + 16'h0001;
                end
            end
        end
    endgenerate
    wire fault_evt = |fan_fault;

    // interrupt events and status, set wins over clear
    wire resume_evt = forced_d_ff & ~forced & ~fail_ff;
    wire forced_evt = ~forced_d_ff & forced;
    wire [2:0] irq_evt = {forced_evt, resume_evt, fault_evt};
    wire [2:0] nxt_irq_stat = (irq_stat_ff & ~w1c) | irq_evt;

    // read data mux
    wire [31:0] status_word = {8'h00, temp_in, 5'h00, fail_ff, startup,
        forced, duty_ff};
    wire [31:0] rd_word =
        (s_axi_araddr_in == OFS_CTRL) ? ctrl_ff :
        (s_axi_araddr_in == OFS_CURVE) ? curve_ff :
        (s_axi_araddr_in == OFS_STATUS) ? status_word :
        (s_axi_araddr_in == OFS_IRQ_STAT) ? {29'h0000_0000, irq_stat_ff} :
        (s_axi_araddr_in == OFS_IRQ_MASK) ? {29'h0000_0000, irq_mask_ff} :
        (s_axi_araddr_in == OFS_FAN_SPEED_PULSE_IN) ? {fan_speed_pulse_in_last[1], fan_speed_pulse_in_last[0]} :
        (s_axi_araddr_in == OFS_FAN_SPEED_PULSE_IN_LIM) ? lim_ff : 32'h0000_0000;
    wire rd_hit = (s_axi_araddr_in <= OFS_FAN_SPEED_PULSE_IN_LIM) &
        (s_axi_araddr_in[1:0] == 2'h0);

    // axi write channel
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else
        begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff <= nxt_w_have;
            awready_ff <= ~nxt_aw_have;
            wready_ff <= ~nxt_w_have;
            if (aw_fire)
                awaddr_ff <= s_axi_awaddr_in;
            if (w_fire)
            begin
                wdata_ff <= s_axi_wdata_in;
                wstrb_ff <= s_axi_wstrb_in;
            end
            if (do_wr)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready_in)
                bvalid_ff <= 1'b0;
        end
    end

    // axi read channel
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end
        else
        begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= ~nxt_rvalid;
            if (ar_fire)
            begin
                rdata_ff <= rd_hit ? rd_word : 32'h0000_0000;
                rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // software registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl_ff <= RST_CTRL;
            curve_ff <= RST_CURVE;
            lim_ff <= RST_FAN_SPEED_PULSE_IN_LIM;
            irq_mask_ff <= RST_IRQ_MASK;
            irq_stat_ff <= 3'h0;
            irq_ff <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= {23'h00_0000, wmerge_ctrl[8:0]};
            if (wr_curve)
                curve_ff <= {16'h0000, wmerge_curve[15:0]};
            if (wr_lim)
                lim_ff <= wmerge_lim;
            if (wr_imask)
                irq_mask_ff <= wdata_ff[2:0];
            irq_stat_ff <= nxt_irq_stat;
            irq_ff <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    // mode sequence and forced speed timers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mode_ff <= MODE_STARTUP;
            tick_cnt_ff <= 32'h0000_0000;
            start_cnt_ff <= 32'h0000_0000;
            bk_cnt_ff <= 32'h0000_0000;
            hold_cnt_ff <= 32'h0000_0000;
            backup_d_ff <= 1'b0;
            test_d_ff <= 1'b0;
            forced_d_ff <= 1'b1;
            win_cnt_ff <= 16'h0000;
            fail_ff <= 1'b0;
        end
        else
        begin
            tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
            backup_d_ff <= backup_in;
            test_d_ff <= battery_test_in;
            forced_d_ff <= forced;
            if (win_end || !mon_en)
                win_cnt_ff <= 16'h0000;
            else if (tick)
                win_cnt_ff <= win_cnt_ff + 16'h0001;
            // backup duration, saturating
            if (!backup_in)
                bk_cnt_ff <= 32'h0000_0000;
            else if (tick && bk_cnt_ff < 32'(BACKUP_LONG_TICKS_P))
                bk_cnt_ff <= bk_cnt_ff + 32'h0000_0001;
            // hold start after a test or long backup ends
            if (hold_start)
                hold_cnt_ff <= 32'(HOLD_TICKS_P); // R10
            else if (tick && hold)
                hold_cnt_ff <= hold_cnt_ff - 32'h0000_0001;
            if (fault_evt)
                fail_ff <= 1'b1; // R6 R7
            case (mode_ff)
                MODE_STARTUP:
                begin
                    if (tick)
                        start_cnt_ff <= start_cnt_ff + 32'h0000_0001;
                    if (start_cnt_ff >= 32'(STARTUP_TICKS_P))
                        mode_ff <= MODE_REGULATE; // R5
                end
                MODE_FORCED:
                    mode_ff <= fault_evt ? MODE_FAULT :
                        (forced ? MODE_FORCED : MODE_REGULATE);
                MODE_REGULATE:
                    mode_ff <= fault_evt ? MODE_FAULT :
                        (forced ? MODE_FORCED : MODE_REGULATE);
                MODE_FAULT:
                    mode_ff <= MODE_FAULT;
                default:
                    mode_ff <= MODE_FAULT;
            endcase
        end
    end

    // duty register and pwm carrier
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            duty_ff <= DUTY_FULL;
            pre_cnt_ff <= 32'h0000_0000;
            pwm_cnt_ff <= 7'h00;
            pwm_ff <= 1'b1;
        end
        else
        begin
            duty_ff <= target_duty; // R1 R4 R11
            if (pre_cnt_ff == 32'(PWM_STEP_CYC - 1))
            begin
                pre_cnt_ff <= 32'h0000_0000;
                pwm_cnt_ff <= (pwm_cnt_ff == 7'h63) ? 7'h00 :
                    pwm_cnt_ff + 7'h01;
            end
            else
                pre_cnt_ff <= pre_cnt_ff + 32'h0000_0001;
            pwm_ff <= ({1'b0, pwm_cnt_ff} < duty_ff);
        end
    end

    // outputs straight from flops
    assign fan_pwm_out = pwm_ff;
    assign fail_led_out = fail_ff;
    assign shutdown_out = fail_ff;
    assign irq_out = irq_ff;
    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out = wready_ff;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign s_axi_rresp_out = rresp_ff;

    // checks on the duty law, forcing and fault handling
    a_duty_floor: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        duty_ff >= DUTY_FLOOR_MIN)
        else $error("duty below 30 percent");
    a_floor_raise: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        !forced && !fail_ff && ctrl_ff.floor_pct > DUTY_FLOOR_MIN &&
        ctrl_ff.floor_pct <= DUTY_FULL |=> duty_ff >= $past(ctrl_ff.floor_pct))
        else $error("configured floor not honoured");
    a_curve_follow: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        !forced && !fail_ff |=> duty_ff == $past(curve_duty))
        else $error("duty does not follow temperature curve");
    a_duty_steady: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        $stable(temp_in) && $stable(forced) && $stable(ctrl_ff) &&
        $stable(curve_ff) && $stable(fail_ff) |=> $stable(duty_ff))
        else $error("duty changed without a cause");
    a_startup_full: assert property (@(posedge clk_in) disable iff (rst_in) // R5
        startup |=> duty_ff == DUTY_FULL)
        else $error("fan not at full speed during startup");
    a_fault_shut: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        fault_evt |=> shutdown_out ##1 shutdown_out)
        else $error("fan fault did not shut down");
    a_fault_led: assert property (@(posedge clk_in) disable iff (rst_in) // R7
        fault_evt |=> fail_led_out ##1 duty_ff == DUTY_FULL)
        else $error("fan fault did not light fail led");
    a_second_fan: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        fan_fault[1] |-> ctrl_ff.two_fan ##1 fail_ff)
        else $error("second fan fault mishandled");
    a_backup_full: assert property (@(posedge clk_in) disable iff (rst_in) // R9
        backup_in || battery_test_in |=> duty_ff == DUTY_FULL)
        else $error("backup or test not at full speed");
    a_test_hold: assert property (@(posedge clk_in) disable iff (rst_in) // R10
        $fell(battery_test_in) |=> ##1 hold_cnt_ff >= 32'(HOLD_TICKS_P - 1)
        && duty_ff == DUTY_FULL)
        else $error("full speed hold not started");
    a_resume_run: assert property (@(posedge clk_in) disable iff (rst_in) // R11
        $fell(forced) && !fail_ff |=> duty_ff >= floor_cap && duty_ff != 0)
        else $error("fan stopped when leaving forced speed");

endmodule

// >>> fan_fan_speed_pulse_in_model.sv
// Purpose: behavioural model of one or two four-wire fans, fan_speed_pulse_in side
// Assumes: period_in counts clock cycles per fan_speed_pulse_in pulse, 0 means stopped
// Notes: a stopped fan leaves its open-collector fan_speed_pulse_in at the pull-up level
`timescale 1ns/1ps
module fan_fan_speed_pulse_in_model
(
    input wire logic clk_in,
    input wire logic [1:0][15:0] period_in,
    output logic [1:0] fan_speed_pulse_out
);
    logic [1:0][15:0] cnt_ff = '0;

    // free-running pulse counters, one per fan
    always_ff @(posedge clk_in)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (period_in[i] == 16'h0000 || cnt_ff[i] >= period_in[i] - 1)
                cnt_ff[i] <= 16'h0000;
            else
                cnt_ff[i] <= cnt_ff[i] + 16'h0001;
        end
    end

    // high for the first half of each period, high when stopped
    for (genvar i = 0; i < 2; i++)
    begin : g_fan
        assign fan_speed_pulse_out[i] = (period_in[i] == 16'h0000) ||
            (cnt_ff[i] < (period_in[i] >> 1));
    end
endmodule

// >>> psu_fan_speed_control_tb_top.sv
// Purpose: self-checking bench for the fan speed controller
// Assumes: shortened tick and timer parameters, fan model on the fan_speed_pulse_in
// Notes: register reads and write responses checked by a monitor
`timescale 1ns/1ps
module psu_fan_speed_control_tb_top import fan_ctrl_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] temp = 8'h14;
    logic backup = 1'b0;
    logic battery = 1'b0;
    logic [1:0][15:0] period = {16'h0000, 16'h0064};
    logic [1:0] pulse;
    logic pwm, fail, shut, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] rq[$];
    logic [31:0] mq[$];
    logic [1:0] bq[$];
    int failures = 0;
    int n_compared = 0;
    int fl, t, w;
    int fls[5] = '{30, 30, 10, 40, 150};
    int tps[5] = '{20, 26, 30, 30, 20};
    logic [15:0] fp0[3] = '{16'h0064, 16'h0000, 16'h0005};
    logic [15:0] fp1[3] = '{16'h0000, 16'h0064, 16'h0064};

    always #5 clk_in = ~clk_in;

    fan_speed_ctrl #(.TICK_CYC_P(10), .STARTUP_TICKS_P(3),
        .BACKUP_LONG_TICKS_P(5), .HOLD_TICKS_P(4)) uut (
        .clk_in(clk_in), .rst_in(rst_in), .temp_in(temp),
        .backup_in(backup), .battery_test_in(battery),
        .fan_speed_pulse_in(pulse), .fan_pwm_out(pwm),
        .fail_led_out(fail), .shutdown_out(shut), .irq_out(irq),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready));

    fan_fan_speed_pulse_in_model fans (.clk_in(clk_in), .period_in(period),
        .fan_speed_pulse_out(pulse));

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        cyc(8);
        rst_in <= 1'b0;
    endtask

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge clk_in);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask

    // read: expected word and compare mask noted before the request
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m, input logic [1:0] r);
        @(posedge clk_in);
        rq.push_back({r, e & m});
        mq.push_back(m);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic pwm_chk(input int pct);
        int hi;
        hi = 0;
        cyc(3);
        repeat (PWM_PERIOD_CYC) @(posedge clk_in) hi += int'(pwm);
        chk("pwm high cycles", 32'(pct * PWM_STEP_CYC), 32'(hi));
    endtask

    function automatic logic [7:0] exp_duty(input int f, input int tc);
        int d;
        f = f < 30 ? 30 : (f > 100 ? 100 : f);
        d = tc > 25 ? f + (tc - 25) * 2 : f;
        return 8'(d > 100 ? 100 : d);
    endfunction

    // monitor: oldest note against each answer as it is handed over
    always @(posedge clk_in)
    begin
        if (rvalid && rready && rq.size() > 0)
        begin
            chk("read data", rq[0][31:0], rdata & mq[0]);
            chk("read resp", 32'(rq[0][33:32]), 32'(rresp));
            void'(rq.pop_front());
            void'(mq.pop_front());
        end
        if (bvalid && bready && bq.size() > 0)
        begin
            chk("write resp", 32'(bq[0]), 32'(bresp));
            void'(bq.pop_front());
        end
    end

    // watchdog
    initial
    begin
        repeat (90000) @(posedge clk_in);
        failures++;
        results();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'h7b93));
        do_reset();
        rd(OFS_STATUS, 32'h0000_0264, 32'h0000_02ff, RESP_OKAY);
        cyc(40);
        rd(OFS_CTRL, RST_CTRL, '1, RESP_OKAY);
        rd(OFS_CURVE, RST_CURVE, '1, RESP_OKAY);
        rd(OFS_FAN_SPEED_PULSE_IN_LIM, RST_FAN_SPEED_PULSE_IN_LIM, '1, RESP_OKAY);
        rd(OFS_IRQ_MASK, 32'h0000_0000, '1, RESP_OKAY);
        rd(8'h1c, 32'h0000_0000, '1, RESP_SLVERR);
        wr(8'h1c, 32'h0000_0000, RESP_SLVERR);
        // floor and temperature law, fixed corners then random points
        for (int i = 0; i < 10; i++)
        begin
            fl = i < 5 ? fls[i] : $urandom_range(120);
            t = i < 5 ? tps[i] : $urandom_range(90);
            temp <= 8'(t);
            wr(OFS_CTRL, 32'(fl), RESP_OKAY);
            rd(OFS_STATUS, {8'h00, 8'(t), 8'h00, exp_duty(fl, t)},
                32'h00ff_00ff, RESP_OKAY);
        end
        temp <= 8'h14;
        wr(OFS_CTRL, 32'h0000_001e, RESP_OKAY);
        pwm_chk(30);
        // battery test, short backup, long backup
        for (int i = 0; i < 3; i++)
        begin
            battery <= (i == 0);
            backup <= (i != 0);
            rd(OFS_STATUS, 32'h0000_0164, 32'h0000_01ff, RESP_OKAY);
            if (i == 0)
                pwm_chk(100);
            else
                cyc(i == 1 ? 20 : 100);
            battery <= 1'b0;
            backup <= 1'b0;
            cyc(15);
            rd(OFS_STATUS, 32'(i == 1 ? 30 : 100), 32'h0000_00ff,
                RESP_OKAY);
            cyc(80);
            rd(OFS_STATUS, 32'h0000_001e, 32'h0000_00ff, RESP_OKAY);
        end
        // events masked, unmasked, then cleared
        chk("irq level", 32'h0000_0000, 32'(irq));
        rd(OFS_IRQ_STAT, 32'h0000_0006, 32'h0000_0007, RESP_OKAY);
        wr(OFS_IRQ_MASK, 32'h0000_0006, RESP_OKAY);
        cyc(2);
        chk("irq level", 32'h0000_0001, 32'(irq));
        wr(OFS_IRQ_STAT, 32'h0000_0006, RESP_OKAY);
        cyc(2);
        chk("irq level", 32'h0000_0000, 32'(irq));
        // second fan stopped but not fitted: no fault
        cyc(21000);
        chk("fail led", 32'h0000_0000, 32'(fail));
        rd(OFS_FAN_SPEED_PULSE_IN, 32'h0000_0064, '1, RESP_OKAY);
        // stopped second fan, blocked first fan, implausible speed
        for (int i = 0; i < 3; i++)
        begin
            do_reset();
            period <= {fp1[i], fp0[i]};
            wr(OFS_CTRL, i == 0 ? 32'h0000_011e : 32'h0000_001e, RESP_OKAY);
            w = 0;
            while (fail !== 1'b1 && w < 25000)
            begin
                @(posedge clk_in);
                w++;
            end
            chk("fail led", 32'h0000_0001, 32'(fail));
            chk("shutdown", 32'h0000_0001, 32'(shut));
            rd(OFS_STATUS, 32'h0000_0464, 32'h0000_04ff, RESP_OKAY);
            rd(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
        end
        results();
    end
endmodule
